/* design/mocr_consts.svh */
`ifndef MOCR_CONSTS_SVH
`define MOCR_CONSTS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define MOCR_IDX_OFFSET    8'h72
`define MOCR_IDX_CONFIG    8'h73
`define MOCR_IDX_AUX       8'h80
`define MOCR_IDX_LO        2
`define MOCR_IDX_HI        9
`define MOCR_ADDR_W        12

// ************************************************************
// reset values
// ************************************************************
`define MOCR_OFFSET_RESET  8'h00
`define MOCR_CONFIG_RESET  8'h00
`define MOCR_AUX_RESET     9'h000

// ************************************************************
// second configuration register fields
// ************************************************************
`define MOCR_CFG_PRES      0
`define MOCR_CFG_FAN_LO    1
`define MOCR_CFG_FAN_HI    3
`define MOCR_CFG_AVG       4
`define MOCR_CFG_ATTENUATOR_BYPASS      5
`define MOCR_CFG_SINGLE_CHANNEL_SAMPLING      6

// ************************************************************
// auxiliary link register fields
// ************************************************************
`define MOCR_AUX_LOCK      0
`define MOCR_AUX_RANGE     1
`define MOCR_AUX_ATT_LO    2
`define MOCR_AUX_ATT_HI    5
`define MOCR_AUX_SEL_LO    6
`define MOCR_AUX_SEL_HI    8

// ************************************************************
// bus answers, measurement limits, timing
// ************************************************************
`define MOCR_RESP_OKAY     2'h0
`define MOCR_RESP_DECERR   2'h3
`define MOCR_MEAS_MAX      10'h3FF
`define MOCR_MEAS_ZERO     10'h000
`define MOCR_AVG_SAMPLES   5'h10
`define MOCR_ONE_SAMPLE    5'h01
`define MOCR_LAST_CHAN     3'h7

`endif

/* design/mocr_pkg.sv */
`include "mocr_consts.svh"

package mocr_pkg;

  // write path of the register slave
  typedef enum logic [1:0] {
    MOCR_WR_COLLECT = 2'h0,
    MOCR_WR_APPLY   = 2'h1,
    MOCR_WR_RESP    = 2'h3
  } mocr_wr_state_t;

  // read path of the register slave
  typedef enum logic {
    MOCR_RD_IDLE = 1'h0,
    MOCR_RD_RESP = 1'h1
  } mocr_rd_state_t;

  // converter input codes
  typedef enum logic [2:0] {
    MOCR_CH_V2P5     = 3'h0,
    MOCR_CH_CORE     = 3'h1,
    MOCR_CH_SUPPLY   = 3'h2,
    MOCR_CH_V5P0     = 3'h3,
    MOCR_CH_V12      = 3'h4,
    MOCR_CH_REMOTE1  = 3'h5,
    MOCR_CH_LOCAL    = 3'h6,
    MOCR_CH_REMOTE2  = 3'h7
  } mocr_chan_t;

endpackage : mocr_pkg

/* design/mocr_axil_slave.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mocr_consts.svh"

module mocr_axil_slave
  import mocr_pkg::*;
(
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // write address and data
  input  wire logic [`MOCR_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  // write response
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  // read address and data
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // register file side
  output logic                        wr_pulse,
  output logic [`MOCR_ADDR_W-1:0]     wr_addr,
  output logic [31:0]                 wr_data,
  output logic [3:0]                  wr_strb,
  input  wire logic                   wr_hit,
  input  wire logic [31:0]            rd_word,
  input  wire logic                   rd_hit
);

  mocr_wr_state_t             wr_state, next_wr_state;
  mocr_rd_state_t             rd_state, next_rd_state;
  logic                       aw_held, next_aw_held;
  logic                       w_held, next_w_held;
  logic [`MOCR_ADDR_W-1:0]    next_wr_addr;
  logic [31:0]                next_wr_data, next_rdata;
  logic [3:0]                 next_wr_strb;
  logic [1:0]                 next_bresp, next_rresp;

  // address and data may arrive in either order; each is held once taken
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_strb  = wr_strb;
    next_bresp    = bresp;
    unique case (wr_state)
      MOCR_WR_COLLECT: begin
        if (awvalid && awready) begin
          next_aw_held = 1'b1;
          next_wr_addr = awaddr;
        end
        if (wvalid && wready) begin
          next_w_held  = 1'b1;
          next_wr_data = wdata;
          next_wr_strb = wstrb;
        end
        if (next_aw_held && next_w_held)
          next_wr_state = MOCR_WR_APPLY;
      end
      MOCR_WR_APPLY: begin
        next_aw_held  = 1'b0;
        next_w_held   = 1'b0;
        next_bresp    = wr_hit ? `MOCR_RESP_OKAY : `MOCR_RESP_DECERR;
        next_wr_state = MOCR_WR_RESP;
      end
      MOCR_WR_RESP: begin
        if (bready)
          next_wr_state = MOCR_WR_COLLECT;
      end
      default: next_wr_state = MOCR_WR_COLLECT;
    endcase
  end

  // read answers one cycle after the address is taken
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    unique case (rd_state)
      MOCR_RD_IDLE: begin
        if (arvalid && arready) begin
          next_rdata    = rd_hit ? rd_word : 32'h0000_0000;
          next_rresp    = rd_hit ? `MOCR_RESP_OKAY : `MOCR_RESP_DECERR;
          next_rd_state = MOCR_RD_RESP;
        end
      end
      MOCR_RD_RESP: begin
        if (rready)
          next_rd_state = MOCR_RD_IDLE;
      end
    endcase
  end

  // every handshake output is a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= MOCR_WR_COLLECT;
      rd_state <= MOCR_RD_IDLE;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= 32'h0000_0000;
      wr_strb  <= 4'h0;
      bresp    <= `MOCR_RESP_OKAY;
      rdata    <= 32'h0000_0000;
      rresp    <= `MOCR_RESP_OKAY;
      awready  <= 1'b0;
      wready   <= 1'b0;
      arready  <= 1'b0;
      bvalid   <= 1'b0;
      rvalid   <= 1'b0;
      wr_pulse <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
      wr_strb  <= next_wr_strb;
      bresp    <= next_bresp;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      awready  <= (next_wr_state == MOCR_WR_COLLECT) && !next_aw_held;
      wready   <= (next_wr_state == MOCR_WR_COLLECT) && !next_w_held;
      arready  <= (next_rd_state == MOCR_RD_IDLE);
      bvalid   <= (next_wr_state == MOCR_WR_RESP);
      rvalid   <= (next_rd_state == MOCR_RD_RESP);
      wr_pulse <= (next_wr_state == MOCR_WR_APPLY);
    end
  end

endmodule : mocr_axil_slave

`default_nettype wire

/* design/mocr_chan_select.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mocr_consts.svh"

module mocr_chan_select
  import mocr_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // mode and selection
  input  wire logic       single_mode,
  input  wire logic [2:0] select_code,
  input  wire logic       conversion_done,
  // converter steering
  output mocr_chan_t      chan,
  output logic [7:0]      chan_onehot
);

  logic [2:0] rr_code, next_rr_code;
  mocr_chan_t next_chan;
  logic [7:0] next_onehot;

  // round robin walks all eight inputs; single mode pins one of them
  always_comb begin
    next_rr_code = rr_code;
    if (conversion_done)
      next_rr_code = (rr_code == `MOCR_LAST_CHAN) ? 3'h0 : rr_code + 3'h1;
    next_chan = single_mode ? mocr_chan_t'(select_code)
                            : mocr_chan_t'(next_rr_code);
  end

  // one enable line per converter input
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_onehot
      assign next_onehot[gi] = (next_chan == mocr_chan_t'(gi));
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rr_code     <= 3'h0;
      chan        <= MOCR_CH_V2P5;
      chan_onehot <= 8'h01;
    end else begin
      rr_code     <= next_rr_code;
      chan        <= next_chan;
      chan_onehot <= next_onehot;
    end
  end

endmodule : mocr_chan_select

`default_nettype wire

/* design/mocr_top.sv */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "mocr_consts.svh"

// ************************************************************
// offset and second configuration registers of the monitor
// ************************************************************

module mocr_top
  import mocr_pkg::*;
(
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [`MOCR_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  // axi4-lite write data
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // axi4-lite write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read address
  input  wire logic [`MOCR_ADDR_W-1:0] araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  // axi4-lite read data
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // four-wire sense pins of the three tachometer inputs
  input  wire logic [2:0]              tach_four_wire_sense,
  // remote two measurement from the converter
  input  wire logic [9:0]              remote_two_raw,
  input  wire logic                    remote_two_raw_valid,
  input  wire logic                    conversion_done,
  // corrected remote two measurement
  output logic [9:0]                   remote_two_corrected,
  output logic                         remote_two_corrected_valid,
  // converter and front-end control
  output logic                         averaging_off,
  output logic [4:0]                   samples_per_result,
  output logic [3:0]                   attenuator_bypass,
  output logic                         single_channel_sampling,
  output mocr_chan_t                   adc_channel,
  output logic [7:0]                   adc_channel_onehot
);

  // ************************************************************
  // register bus slave
  // ************************************************************

  logic                     wr_pulse;
  logic [`MOCR_ADDR_W-1:0]  wr_addr;
  logic [31:0]              wr_data;
  logic [3:0]               wr_strb;
  logic                     wr_hit;
  logic [31:0]              rd_word;
  logic                     rd_hit;
  logic [7:0]               wr_index;
  logic [7:0]               rd_index;

  mocr_axil_slave u_slave (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .wr_pulse (wr_pulse),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_strb  (wr_strb),
    .wr_hit   (wr_hit),
    .rd_word  (rd_word),
    .rd_hit   (rd_hit)
  );

  // protection attributes carry no meaning for this bank
  logic prot_unused;
  assign prot_unused = ^{awprot, arprot};

  // word index; the low two address bits are ignored
  assign wr_index = wr_addr[`MOCR_IDX_HI:`MOCR_IDX_LO];
  assign rd_index = araddr[`MOCR_IDX_HI:`MOCR_IDX_LO];

  // decode of the three mapped words; upper address bits must be zero
  assign wr_hit = (wr_addr[`MOCR_ADDR_W-1:`MOCR_IDX_HI+1] == '0)
                && ((wr_index == `MOCR_IDX_OFFSET)
                 || (wr_index == `MOCR_IDX_CONFIG)
                 || (wr_index == `MOCR_IDX_AUX));
  assign rd_hit = (araddr[`MOCR_ADDR_W-1:`MOCR_IDX_HI+1] == '0)
                && ((rd_index == `MOCR_IDX_OFFSET)
                 || (rd_index == `MOCR_IDX_CONFIG)
                 || (rd_index == `MOCR_IDX_AUX));

  // ************************************************************
  // register state
  // ************************************************************

  logic [7:0] remote_two_temp_offset, next_offset;
  logic       fan_presence_sense_enable, next_pres_en;
  logic       next_avg_off, next_attenuator_bypass, next_single;
  logic [8:0] aux_control, next_aux;
  logic [2:0] fan_seen, next_fan_seen;
  logic       attenuator_bypass_all;
  logic       locked;
  // a literal cannot be bit-selected, so the reset word gets a name here
  localparam logic [7:0] CFG_RST = `MOCR_CONFIG_RESET;
  logic       wr_offset, wr_config, wr_aux;

  assign locked    = aux_control[`MOCR_AUX_LOCK];
  assign wr_offset = wr_pulse && wr_strb[0] && (wr_index == `MOCR_IDX_OFFSET);
  assign wr_config = wr_pulse && wr_strb[0] && (wr_index == `MOCR_IDX_CONFIG);
  assign wr_aux    = wr_pulse && (wr_index == `MOCR_IDX_AUX);

  // next values of the software registers
  always_comb begin
    next_offset  = remote_two_temp_offset;
    next_pres_en = fan_presence_sense_enable;
    next_avg_off = averaging_off;
    next_attenuator_bypass    = attenuator_bypass_all;
    next_single  = single_channel_sampling;
    next_aux     = aux_control;
    if (wr_offset && !locked)
      next_offset = wr_data[7:0];
    // flags 3..1 and the spare top bit are not stored by a write
    if (wr_config && !locked) begin
      next_pres_en = wr_data[`MOCR_CFG_PRES];
      next_avg_off = wr_data[`MOCR_CFG_AVG];
      next_attenuator_bypass    = wr_data[`MOCR_CFG_ATTENUATOR_BYPASS];
      next_single  = wr_data[`MOCR_CFG_SINGLE_CHANNEL_SAMPLING];
    end
    if (wr_aux) begin
      if (wr_strb[0])
        next_aux[7:0] = wr_data[7:0];
      if (wr_strb[1])
        next_aux[8] = wr_data[8];
      // lock is sticky: only reset opens the bank again
      if (locked)
        next_aux[`MOCR_AUX_LOCK] = 1'b1;
    end
  end

  // reset clears all three registers to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_two_temp_offset    <= `MOCR_OFFSET_RESET;
      fan_presence_sense_enable <= CFG_RST[`MOCR_CFG_PRES];
      averaging_off             <= CFG_RST[`MOCR_CFG_AVG];
      attenuator_bypass_all     <= CFG_RST[`MOCR_CFG_ATTENUATOR_BYPASS];
      single_channel_sampling   <= CFG_RST[`MOCR_CFG_SINGLE_CHANNEL_SAMPLING];
      aux_control               <= `MOCR_AUX_RESET;
    end else begin
      remote_two_temp_offset    <= next_offset;
      fan_presence_sense_enable <= next_pres_en;
      averaging_off             <= next_avg_off;
      attenuator_bypass_all     <= next_attenuator_bypass;
      single_channel_sampling   <= next_single;
      aux_control               <= next_aux;
    end
  end

  // ************************************************************
  // fan presence sensing
  // ************************************************************

  logic [2:0] sense_meta, sense_sync;

  // sense pins are asynchronous; two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_meta <= 3'h0;
      sense_sync <= 3'h0;
    end else begin
      sense_meta <= tach_four_wire_sense;
      sense_sync <= sense_meta;
    end
  end

  // flags read zero while sensing is disabled
  always_comb begin
    next_fan_seen = fan_presence_sense_enable ? sense_sync : 3'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      fan_seen <= 3'h0;
    else
      fan_seen <= next_fan_seen;
  end

  // ************************************************************
  // read word
  // ************************************************************

  logic [7:0] config_word;

  // bit order: spare, single, bypass, avg off, fans three..one, enable
  assign config_word = {1'b0, single_channel_sampling, attenuator_bypass_all,
                        averaging_off, fan_seen,
                        fan_presence_sense_enable};

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_index == `MOCR_IDX_OFFSET)
      rd_word[7:0] = remote_two_temp_offset;
    else if (rd_index == `MOCR_IDX_CONFIG)
      rd_word[7:0] = config_word;
    else if (rd_index == `MOCR_IDX_AUX)
      rd_word[8:0] = aux_control;
  end

  // ************************************************************
  // remote two offset correction
  // ************************************************************

  logic signed [11:0] raw_ext, offset_ext, next_sum;
  logic [9:0]         next_corrected;
  logic [7:0]         ofs;

  assign ofs = remote_two_temp_offset;

  // readings carry two fraction bits; the offset is either whole
  // degrees (extended range) or half degrees (fine resolution)
  always_comb begin
    raw_ext = signed'({2'h0, remote_two_raw});
    if (aux_control[`MOCR_AUX_RANGE])
      offset_ext = signed'({{2{ofs[7]}}, ofs, 2'h0});
    else
      offset_ext = signed'({{3{ofs[7]}}, ofs, 1'h0});
    next_sum = raw_ext + offset_ext;
    // clamp rather than wrap so a large offset cannot fold the reading
    if (next_sum[11])
      next_corrected = `MOCR_MEAS_ZERO;
    else if (next_sum[10])
      next_corrected = `MOCR_MEAS_MAX;
    else
      next_corrected = next_sum[9:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_two_corrected       <= `MOCR_MEAS_ZERO;
      remote_two_corrected_valid <= 1'b0;
    end else begin
      if (remote_two_raw_valid)
        remote_two_corrected <= next_corrected;
      remote_two_corrected_valid <= remote_two_raw_valid;
    end
  end

  // ************************************************************
  // converter front-end control
  // ************************************************************

  logic [4:0] next_samples;
  logic [3:0] next_bypass;

  // bypass order: 2.5 V, core, 5.0 V, 12 V; supply input is never attenuated
  always_comb begin
    next_samples = averaging_off ? `MOCR_ONE_SAMPLE
                                 : `MOCR_AVG_SAMPLES;
    next_bypass  = {4{attenuator_bypass_all}}
                 | aux_control[`MOCR_AUX_ATT_HI:`MOCR_AUX_ATT_LO];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samples_per_result <= `MOCR_AVG_SAMPLES;
      attenuator_bypass  <= 4'h0;
    end else begin
      samples_per_result <= next_samples;
      attenuator_bypass  <= next_bypass;
    end
  end

  // input selection, round robin or single channel
  mocr_chan_select u_chan (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .single_mode     (single_channel_sampling),
    .select_code     (aux_control[`MOCR_AUX_SEL_HI:`MOCR_AUX_SEL_LO]),
    .conversion_done (conversion_done),
    .chan            (adc_channel),
    .chan_onehot     (adc_channel_onehot)
  );

endmodule : mocr_top

`default_nettype wire

/* tb/mocr_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

module mocr_top_asserts
  import mocr_pkg::*;
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  // measurement and control
  input wire logic       remote_two_raw_valid,
  input wire logic       remote_two_corrected_valid,
  input wire logic       conversion_done,
  input wire logic       averaging_off,
  input wire logic [4:0] samples_per_result,
  input wire logic [3:0] attenuator_bypass,
  input wire logic       single_channel_sampling,
  input wire logic [2:0] adc_channel,
  input wire logic [7:0] adc_channel_onehot
);
  // ************************************************************
  // port relations
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_clear: assert property ($rose(aresetn) |-> !averaging_off
    && !single_channel_sampling && attenuator_bypass == 4'h0
    && samples_per_result == 5'h10) else $error("bad state after reset");
  a_avg_rate: assert property (samples_per_result ==
    ($past(averaging_off) ? 5'h01 : 5'h10)) else $error("bad sample count");
  a_corr_valid: assert property (remote_two_corrected_valid ==
    $past(remote_two_raw_valid)) else $error("corrected valid late");
  a_onehot_code: assert property (adc_channel_onehot ==
    8'h01 << adc_channel) else $error("onehot mismatch");
  // only steps taken wholly in round robin are judged
  a_robin_step: assert property (!single_channel_sampling
    ##1 !single_channel_sampling && conversion_done
    ##1 !single_channel_sampling |->
    adc_channel == 3'($past(adc_channel) + 3'h1)) else $error("bad step");
  a_write_answer: assert property (awvalid && awready && wvalid
    && wready |-> ##2 bvalid) else $error("write answer late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("bvalid dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid
    && !arready) else $error("read answer late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("rvalid dropped");

  c_write: cover property (bvalid && bready);
  c_corr: cover property (remote_two_corrected_valid);
  c_single: cover property (single_channel_sampling && conversion_done);
endmodule : mocr_top_asserts

`default_nettype wire

/* tb/monitor_offset_and_config_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mocr_consts.svh"

module monitor_offset_and_config_regs_bench
  import mocr_pkg::*;
;
  // ************************************************************
  // stimulus, bus tasks and checks
  // ************************************************************
  localparam logic [11:0] AOF = 12'({`MOCR_IDX_OFFSET, 2'b00});
  localparam logic [11:0] ACF = 12'({`MOCR_IDX_CONFIG, 2'b00});
  localparam logic [11:0] AAX = 12'({`MOCR_IDX_AUX, 2'b00});
  localparam logic [1:0]  OK  = `MOCR_RESP_OKAY;
  localparam logic [1:0]  DE  = `MOCR_RESP_DECERR;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic remote_two_raw_valid = 1'b0, conversion_done = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0, tach_four_wire_sense = 3'h5;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF, attenuator_bypass;
  logic [9:0]  remote_two_raw = 10'h000, remote_two_corrected;
  logic awready, wready, bvalid, arready, rvalid, averaging_off;
  logic remote_two_corrected_valid, single_channel_sampling;
  logic [1:0]  bresp, rresp;
  logic [4:0]  samples_per_result;
  logic [7:0]  adc_channel_onehot;
  mocr_chan_t  adc_channel;
  int n_errors = 0, n_tests = 0, cyc = 0;

  mocr_top u_mocr_top (.aclk, .aresetn, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .tach_four_wire_sense, .remote_two_raw, .remote_two_raw_valid,
    .conversion_done, .remote_two_corrected, .remote_two_corrected_valid,
    .averaging_off, .samples_per_result, .attenuator_bypass,
    .single_channel_sampling, .adc_channel, .adc_channel_onehot);

  always #2.5 aclk = ~aclk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      end_of_test();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ready is raised late on purpose so the slave must hold its answer
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(bresp));
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", d, rdata);
    chk("rresp", 32'(r), 32'(rresp));
  endtask : rd

  task raw_in(input logic [9:0] v, input logic [31:0] e);
    @(posedge aclk);
    remote_two_raw <= v;
    remote_two_raw_valid <= 1'b1;
    @(posedge aclk);
    remote_two_raw_valid <= 1'b0;
    @(posedge aclk);
    chk("corr_valid", 32'h1, 32'(remote_two_corrected_valid));
    chk("corrected", e, 32'(remote_two_corrected));
  endtask : raw_in

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(AOF, 32'h0, OK);
    rd(ACF, 32'h0, OK);
    $display("reset values done");
    wr(AOF, 32'hA5, OK);
    rd(AOF, 32'hA5, OK);
    wr(ACF, 32'h7F, OK);
    repeat (4) @(posedge aclk);
    rd(ACF, 32'h7B, OK);
    chk("avg_off", 32'h1, 32'(averaging_off));
    chk("samples", 32'h1, 32'(samples_per_result));
    chk("bypass", 32'hF, 32'(attenuator_bypass));
    chk("single", 32'h1, 32'(single_channel_sampling));
    wr(ACF, 32'h0, OK);
    rd(ACF, 32'h0, OK);
    chk("samples", 32'h10, 32'(samples_per_result));
    repeat (9) begin
      @(posedge aclk);
      conversion_done <= 1'b1;
      @(posedge aclk);
      conversion_done <= 1'b0;
    end
    @(posedge aclk);
    chk("robin", 32'h1, 32'(adc_channel));
    chk("onehot", 32'h2, 32'(adc_channel_onehot));
    $display("configuration bits done");
    wr(ACF, 32'h40, OK);
    for (int c = 0; c < 8; c++) begin
      wr(AAX, 32'(c << 6) | 32'h14, OK);
      repeat (2) @(posedge aclk);
      chk("channel", 32'(c), 32'(adc_channel));
    end
    chk("bypass", 32'h5, 32'(attenuator_bypass));
    rd(AAX, 32'h1D4, OK);
    $display("channel select done");
    wr(AAX, 32'h0, OK);
    wr(AOF, 32'h4, OK);
    raw_in(10'h100, 32'h108);
    wr(AAX, 32'h2, OK);
    raw_in(10'h100, 32'h110);
    wr(AOF, 32'hF0, OK);
    raw_in(10'h010, 32'h0);
    $display("offset correction done");
    wr(AAX, 32'h3, OK);
    wr(AOF, 32'h55, OK);
    rd(AOF, 32'hF0, OK);
    wr(ACF, 32'h10, OK);
    rd(ACF, 32'h40, OK);
    wr(12'h004, 32'h1, DE);
    rd(12'h004, 32'h0, DE);
    $display("lock and unmapped done");
    end_of_test();
  end
endmodule : monitor_offset_and_config_regs_bench

bind mocr_top mocr_top_asserts u_mocr_top_asserts (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
  .arready, .rvalid, .rready, .remote_two_raw_valid,
  .remote_two_corrected_valid, .conversion_done, .averaging_off,
  .samples_per_result, .attenuator_bypass, .single_channel_sampling,
  .adc_channel, .adc_channel_onehot);

`default_nettype wire
